//--- msi_cap_pkg.sv
// Constants for the message signaled interrupt capability block.
// Assumes dword configuration accesses with byte enables.
package msi_cap_pkg;
    localparam logic [7:0]  OFS_CTRL       = 8'h72;
    localparam logic [7:0]  OFS_ADDR_LO    = 8'h74;
    localparam logic [7:0]  OFS_ADDR_HI    = 8'h78;
    localparam logic [7:0]  OFS_DATA       = 8'h7c;
    localparam logic [5:0]  DW_CTRL        = 6'h1c;
    localparam logic [5:0]  DW_ADDR_LO     = 6'h1d;
    localparam logic [5:0]  DW_ADDR_HI     = 6'h1e;
    localparam logic [5:0]  DW_DATA        = 6'h1f;
    localparam int          CTRL_EN_BIT    = 0;
    localparam int          CTRL_CAP_LSB   = 1;
    localparam int          CTRL_MM_LSB    = 4;
    localparam int          CTRL_WIDE_BIT  = 7;
    localparam logic [15:0] CTRL_RESET     = 16'h0080;
    localparam logic [2:0]  MESSAGES_CAPABLE_COUNT_VALUE   = 3'h0;
    localparam logic [2:0]  MM_MAX_LEGAL   = 3'h5;
    localparam logic [31:0] ADDR_LO_RESET  = 32'h0000_0000;
    localparam logic [31:0] ADDR_LO_MASK   = 32'hffff_fffc;
    localparam logic [31:0] ADDR_HI_RESET  = 32'h0000_0000;
    localparam logic [15:0] DATA_RESET     = 16'h0000;
    localparam int          PEND_W         = 4;
endpackage : msi_cap_pkg

//--- msi_capability_registers.sv
// Message signaled interrupt capability: control, address, data registers
// and the memory write request that carries each interrupt upstream.
// Assumes config reads and writes are one-cycle strobes and the upstream
// sender holds off with msg_ready.
// Behaviour
// - Control bits 15:8 read zero, writes ignored
// - Wide address capable bit fixed at one
// - Three-bit messages allowed field is writable
// - Messages capable field reads constant zero
// - Messages launched only while enable is one
// - Address low bits 1:0 read zero
// - Zero upper address selects 32-bit write
// - Interrupt is a write to programmed address
// - Payload is the programmed data value
// - Vector number bits never altered by hardware
`timescale 1ns/1ps
module msi_capability_registers #(
    parameter int PEND_W = msi_cap_pkg::PEND_W
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cfg_wr,
    input  wire logic        cfg_rd,
    input  wire logic [5:0]  cfg_dw,
    input  wire logic [3:0]  cfg_be,
    input  wire logic [31:0] cfg_wdata,
    output logic      [31:0] cfg_rdata,
    output logic             cfg_rd_done,
    input  wire logic        irq_event,
    output logic             msg_valid,
    input  wire logic        msg_ready,
    output logic      [63:0] msg_addr,
    output logic             msg_wide,
    output logic      [15:0] msg_data,
    output logic             event_dropped
);
    logic              enable_r;
    logic [2:0]        messages_allowed_count_r;
    logic [31:0]       addr_lo_r;
    logic [31:0]       addr_hi_r;
    logic [15:0]       data_r;
    logic [15:0]       ctrl_view;
    logic [31:0]       rd_nxt;
    logic [PEND_W-1:0] pend_r;
    logic              take;
    logic              launch;
    logic              pend_full;

    always_comb begin
        ctrl_view = 16'h0000;
        ctrl_view[msi_cap_pkg::CTRL_WIDE_BIT] = 1'b1;
        ctrl_view[msi_cap_pkg::CTRL_MM_LSB +: 3] =
            messages_allowed_count_r;
        ctrl_view[msi_cap_pkg::CTRL_CAP_LSB +: 3] =
            msi_cap_pkg::MESSAGES_CAPABLE_COUNT_VALUE;
        ctrl_view[msi_cap_pkg::CTRL_EN_BIT] = enable_r;
    end

    // Control: only low byte (lane 2) is writable
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r <= msi_cap_pkg::CTRL_RESET[msi_cap_pkg::CTRL_EN_BIT];
            messages_allowed_count_r <=
                msi_cap_pkg::CTRL_RESET[msi_cap_pkg::CTRL_MM_LSB +: 3];
        end else if (cfg_wr && cfg_dw == msi_cap_pkg::DW_CTRL
                     && cfg_be[2]) begin
            enable_r <= cfg_wdata[16 + msi_cap_pkg::CTRL_EN_BIT];
            messages_allowed_count_r <=
                cfg_wdata[16 + msi_cap_pkg::CTRL_MM_LSB +: 3];
        end
    end

    // Address and data registers with byte lanes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_lo_r <= msi_cap_pkg::ADDR_LO_RESET;
            addr_hi_r <= msi_cap_pkg::ADDR_HI_RESET;
            data_r    <= msi_cap_pkg::DATA_RESET;
        end else if (cfg_wr) begin
            for (int i = 0; i < 4; i++) begin
                if (cfg_be[i]) begin
                    if (cfg_dw == msi_cap_pkg::DW_ADDR_LO) begin
                        addr_lo_r[8*i +: 8] <= cfg_wdata[8*i +: 8]
                            & msi_cap_pkg::ADDR_LO_MASK[8*i +: 8];
                    end else if (cfg_dw == msi_cap_pkg::DW_ADDR_HI) begin
                        addr_hi_r[8*i +: 8] <= cfg_wdata[8*i +: 8];
                    end else if (cfg_dw == msi_cap_pkg::DW_DATA
                                 && i < 2) begin
                        data_r[8*i +: 8] <= cfg_wdata[8*i +: 8];
                    end
                end
            end
        end
    end

    // Read path; unmapped dwords read zero
    always_comb begin
        if (cfg_dw == msi_cap_pkg::DW_CTRL) begin
            rd_nxt = {ctrl_view, 16'h0000};
        end else if (cfg_dw == msi_cap_pkg::DW_ADDR_LO) begin
            rd_nxt = addr_lo_r & msi_cap_pkg::ADDR_LO_MASK;
        end else if (cfg_dw == msi_cap_pkg::DW_ADDR_HI) begin
            rd_nxt = addr_hi_r;
        end else if (cfg_dw == msi_cap_pkg::DW_DATA) begin
            rd_nxt = {16'h0000, data_r};
        end else begin
            rd_nxt = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_rdata   <= 32'h0000_0000;
            cfg_rd_done <= 1'b0;
        end else begin
            cfg_rd_done <= cfg_rd;
            if (cfg_rd) begin
                cfg_rdata <= rd_nxt;
            end
        end
    end

    // Pending events; cleared when disabled so nothing is replayed
    assign take      = msg_valid && msg_ready;
    assign launch    = enable_r && (pend_r != '0) && (!msg_valid || take);
    assign pend_full = &pend_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pend_r        <= '0;
            event_dropped <= 1'b0;
        end else begin
            event_dropped <= irq_event && (!enable_r || pend_full);
            if (!enable_r) begin
                pend_r <= '0;
            end else if (irq_event && !pend_full && !launch) begin
                pend_r <= pend_r + PEND_W'(1);
            end else if (launch && !(irq_event && !pend_full)) begin
                pend_r <= pend_r - PEND_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            msg_valid <= 1'b0;
            msg_addr  <= 64'h0000_0000_0000_0000;
            msg_wide  <= 1'b0;
            msg_data  <= 16'h0000;
        end else if (launch) begin
            msg_valid <= 1'b1;
            msg_wide  <= (addr_hi_r != 32'h0000_0000);
            msg_addr  <= {addr_hi_r,
                          addr_lo_r & msi_cap_pkg::ADDR_LO_MASK};
            msg_data  <= data_r;
        end else if (take) begin
            msg_valid <= 1'b0;
        end
    end

    // Checks
    a_ctrl_high_zero: assert property (@(posedge clk)
        disable iff (!rst_n)
        cfg_rd && cfg_dw == msi_cap_pkg::DW_CTRL |=>
        cfg_rdata[31:24] == 8'h00 && cfg_rdata[23] == 1'b1 && cfg_rd_done)
        else $error("control upper byte or wide bit wrong");
    a_wide_bit_one: assert property (@(posedge clk)
        disable iff (!rst_n)
        ctrl_view[msi_cap_pkg::CTRL_WIDE_BIT])
        else $error("wide capable bit not one");
    a_mm_written: assert property (@(posedge clk)
        disable iff (!rst_n)
        cfg_wr && cfg_dw == msi_cap_pkg::DW_CTRL && cfg_be[2] |=>
        messages_allowed_count_r == $past(cfg_wdata[22:20]))
        else $error("allowed count not stored");
    a_cap_zero: assert property (@(posedge clk)
        disable iff (!rst_n)
        cfg_rd && cfg_dw == msi_cap_pkg::DW_CTRL |=>
        cfg_rdata[19:17] == 3'h0)
        else $error("capable count not zero");
    a_no_send_off: assert property (@(posedge clk)
        disable iff (!rst_n)
        !enable_r |=> !$rose(msg_valid))
        else $error("message launched while disabled");
    a_enable_written: assert property (@(posedge clk)
        disable iff (!rst_n)
        cfg_wr && cfg_dw == msi_cap_pkg::DW_CTRL && cfg_be[2] |=>
        enable_r == $past(cfg_wdata[16]))
        else $error("enable bit not stored");
    a_addr_low_zero: assert property (@(posedge clk)
        disable iff (!rst_n)
        addr_lo_r[1:0] == 2'b00 && msg_addr[1:0] == 2'b00)
        else $error("address low bits not zero");
    a_wide_select: assert property (@(posedge clk)
        disable iff (!rst_n)
        $rose(msg_valid) |-> msg_wide == (msg_addr[63:32] != 32'h0000_0000))
        else $error("address width select wrong");
    a_addr_match: assert property (@(posedge clk)
        disable iff (!rst_n)
        launch |=> msg_addr == {$past(addr_hi_r), $past(addr_lo_r)})
        else $error("message address mismatch");
    a_data_match: assert property (@(posedge clk)
        disable iff (!rst_n)
        launch |=> msg_data == $past(data_r))
        else $error("payload differs from programmed data");
    // Event counted at the first edge, launched at the next one
    a_one_per_event: assert property (@(posedge clk)
        disable iff (!rst_n)
        enable_r && irq_event && pend_r == '0 && !msg_valid
        ##1 enable_r && !irq_event |=> msg_valid && pend_r == '0)
        else $error("event not sent exactly once");
    a_drop_when_off: assert property (@(posedge clk)
        disable iff (!rst_n)
        irq_event && !enable_r |=> event_dropped)
        else $error("disabled event not reported as dropped");
    a_pend_cleared: assert property (@(posedge clk)
        disable iff (!rst_n)
        !enable_r |=> pend_r == '0)
        else $error("pending events kept while disabled");
    a_valid_holds: assert property (@(posedge clk)
        disable iff (!rst_n)
        msg_valid && !msg_ready |=> msg_valid && $stable(msg_addr))
        else $error("message dropped before accepted");

    c_send_32: cover property (@(posedge clk) disable iff (!rst_n)
        take && !msg_wide);
    c_send_64: cover property (@(posedge clk) disable iff (!rst_n)
        take && msg_wide);
    c_drop_off: cover property (@(posedge clk) disable iff (!rst_n)
        irq_event && !enable_r);
    c_back_to_back: cover property (@(posedge clk) disable iff (!rst_n)
        take ##1 take);
endmodule : msi_capability_registers

//--- msg_sink.sv
// Upstream receiver model that accepts message write requests.
// Assumes the bench chooses between prompt and stalling acceptance.
`timescale 1ns/1ps
module msg_sink (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic slow,
    output logic      msg_ready
);
    // Ready moves only on the falling edge, away from the sampling edge
    always @(negedge clk or negedge rst_n) begin
        if (!rst_n)
            msg_ready <= 1'b0;
        else
            msg_ready <= !slow || ($urandom % 3 == 0);
    end
endmodule : msg_sink

//--- msi_capability_registers_test.sv
// Self-checking bench for the message interrupt capability registers.
// Assumes msg_sink stands in for the upstream receiver.
`timescale 1ns/1ps
module msi_capability_registers_test;
    logic        clk = 0, rst_n = 0, cfg_wr = 0, cfg_rd = 0;
    logic        irq_event = 0, slow = 0, en = 0;
    logic [5:0]  cfg_dw = '0;
    logic [3:0]  cfg_be = '0;
    logic [31:0] cfg_wdata = '0, cfg_rdata, lo = '0, hi = '0;
    logic [15:0] dat = '0, msg_data;
    logic [63:0] msg_addr;
    logic        cfg_rd_done, msg_valid, msg_ready, msg_wide, event_dropped;
    logic [31:0] rd_q[$];
    logic [80:0] msg_q[$];
    int          n_mismatch = 0, check_count = 0, drops = 0, exp_drops = 0;
    always #50 clk = ~clk;
    msi_capability_registers u_msi_capability_registers (.clk(clk),
        .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_dw(cfg_dw),
        .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
        .cfg_rd_done(cfg_rd_done), .irq_event(irq_event),
        .msg_valid(msg_valid), .msg_ready(msg_ready), .msg_addr(msg_addr),
        .msg_wide(msg_wide), .msg_data(msg_data),
        .event_dropped(event_dropped));
    msg_sink u_msg_sink (.clk(clk), .rst_n(rst_n), .slow(slow),
        .msg_ready(msg_ready));
    task automatic fail(input string m);
        n_mismatch++;
        $display("ERROR %0t %s", $time, m);
    endtask : fail
    task automatic cmp_rd(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) fail($sformatf("read %h expected %h", g, e));
    endtask : cmp_rd
    task automatic cmp_msg(input logic [80:0] g, input logic [80:0] e);
        check_count++;
        if (g !== e) fail($sformatf("message %h expected %h", g, e));
    endtask : cmp_msg
    task automatic cmp_drop(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) fail($sformatf("drops %0d expected %0d", g, e));
    endtask : cmp_drop
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : print_verdict
    task automatic wr(input logic [5:0] d, input logic [3:0] b,
                      input logic [31:0] v);
        @(negedge clk);
        {cfg_wr, cfg_dw, cfg_be, cfg_wdata} = {1'b1, d, b, v};
        @(negedge clk);
        cfg_wr = 0;
    endtask : wr
    task automatic rd(input logic [5:0] d, input logic [31:0] e);
        rd_q.push_back(e);
        @(negedge clk);
        {cfg_rd, cfg_dw} = {1'b1, d};
        @(negedge clk);
        cfg_rd = 0;
    endtask : rd
    task automatic ev();
        if (en)
            msg_q.push_back({hi, lo & 32'hffff_fffc, hi != 0, dat});
        else
            exp_drops++;
        @(negedge clk);
        irq_event = 1;
        @(negedge clk);
        irq_event = 0;
    endtask : ev
    task automatic drain();
        int i;
        for (i = 0; i < 300 && (rd_q.size() + msg_q.size()) > 0; i++)
            @(negedge clk);
        if (rd_q.size() + msg_q.size() > 0) begin
            fail("timeout");
            print_verdict();
        end
    endtask : drain
    always @(posedge clk) begin
        if (cfg_rd_done === 1'b1) begin
            if (rd_q.size() == 0) fail("unexpected read");
            else cmp_rd(cfg_rdata, rd_q.pop_front());
        end
        if (msg_valid === 1'b1 && msg_ready === 1'b1) begin
            if (msg_q.size() == 0) fail("unexpected message");
            else cmp_msg({msg_addr, msg_wide, msg_data},
                         msg_q.pop_front());
        end
        if (event_dropped === 1'b1) drops++;
    end
    initial begin
        void'($urandom(32'hb8b9));
        repeat (10) @(negedge clk);
        rst_n = 1;
        rd(6'h1c, {msi_cap_pkg::CTRL_RESET, 16'h0});
        rd(6'h1d, msi_cap_pkg::ADDR_LO_RESET);
        rd(6'h1e, msi_cap_pkg::ADDR_HI_RESET);
        rd(6'h1f, {16'h0000, msi_cap_pkg::DATA_RESET});
        wr(6'h05, 4'hf, 32'hffff_ffff);
        rd(6'h05, 32'h0000_0000);
        drain();
        $display("test reset values done");
        // Legal allowed-count codes only; reserved ones stay unwritten
        for (int c = 0; c <= 5; c++) begin
            wr(6'h1c, 4'hc, {16'hff0e | 16'(c << 4), 16'hffff});
            rd(6'h1c, {16'h0080 | 16'(c << 4), 16'h0});
        end
        drain();
        $display("test control fields done");
        ev();
        lo = $urandom;
        dat = 16'($urandom);
        wr(6'h1d, 4'hf, lo);
        rd(6'h1d, lo & 32'hffff_fffc);
        wr(6'h1f, 4'h3, {16'h0, dat});
        rd(6'h1f, {16'h0, dat});
        wr(6'h1c, 4'h4, 32'h0001_0000);
        en = 1;
        ev();
        drain();
        $display("test narrow message done");
        hi = $urandom | 32'h1;
        wr(6'h1e, 4'hf, hi);
        rd(6'h1e, hi);
        slow = 1;
        repeat (3) ev();
        drain();
        $display("test wide stalled messages done");
        wr(6'h1c, 4'h4, 32'h0000_0000);
        en = 0;
        ev();
        repeat (30) @(negedge clk);
        cmp_drop(32'(drops), 32'(exp_drops));
        // Re-enable: the dropped event must not be delivered late
        wr(6'h1c, 4'h4, 32'h0001_0000);
        en = 1;
        repeat (30) @(negedge clk);
        ev();
        drain();
        $display("test disabled drop done");
        print_verdict();
    end
endmodule : msi_capability_registers_test
